// ===== src/sequencer_params.svh
// timing counts, thresholds and reset values of the mass clamp and centre sequencer
// Operation
// - every command handles vertical, then north/south, then east/west
// - a recentre that conflicts with the clamped mass state is refused
// - activity indicator lit while a command is carried out, flashing only during centring
// - all lines high and nothing in progress gives low-power idle
// - clamp runs three stages: vertical clamp, then both bases to end stops
// - clamp while already clamped first releases, then clamps again
// - indicator lit during each clamp stage, briefly dark between stages
// - indicator goes dark when the clamp sequence completes
// - release while already released first clamps, then releases again
// - release per axis: free if clamped, level horizontal base, centre
// - centring pulses come further apart as the mass nears centre
// - release ends with an automatic centring round, indicator flashing
// - recentre with no axis off centre causes no motor action
// - recentre ignored when clamped or no position beyond 1.2 V
// - overshoot past centre is corrected by pulses the other way
`ifndef SEQUENCER_PARAMS_SVH
`define SEQUENCER_PARAMS_SVH

`define CLK_PERIOD_NS 50
`define TICK_TIME_NS 1000000
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define TICK_TIME_MS 1
`define CMD_MIN_TIME_MS 200
`define CMD_MIN_TICKS ((`CMD_MIN_TIME_MS + `TICK_TIME_MS - 1) / `TICK_TIME_MS)
`define STAGE_MAX_TIME_MS 30000
`define STAGE_MAX_TICKS (`STAGE_MAX_TIME_MS / `TICK_TIME_MS)
`define STAGE_GAP_TIME_MS 500
`define STAGE_GAP_TICKS (`STAGE_GAP_TIME_MS / `TICK_TIME_MS)
`define PULSE_TIME_MS 100
`define PULSE_TICKS (`PULSE_TIME_MS / `TICK_TIME_MS)
`define PULSE_GAP_TIME_MS 100
`define PULSE_GAP_TICKS (`PULSE_GAP_TIME_MS / `TICK_TIME_MS)
`define BLINK_TIME_MS 250
`define BLINK_TICKS (`BLINK_TIME_MS / `TICK_TIME_MS)
`define MAX_PULSES 1000
// position magnitude in 10 mV steps
`define POS_OVER_CODE 8'h78
`define POS_DONE_CODE 8'h50
`define CLAMPED_AT_RESET 1'b1

`endif

// ===== src/sequencer_pkg.sv
// types of the mass clamp and centre sequencer
package sequencer_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_CL_STAGE = 4'h1,
        ST_CL_GAP = 4'h2,
        ST_REL_FREE = 4'h3,
        ST_REL_LEVEL = 4'h4,
        ST_CEN_CHECK = 4'h5,
        ST_CEN_PULSE = 4'h6,
        ST_CEN_GAP = 4'h7,
        ST_WAIT_HIGH = 4'h8
    } seq_state_t;

    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_CLAMP = 2'h1,
        OP_RELEASE = 2'h2,
        OP_CENTRE = 2'h3
    } op_t;

    typedef logic [7:0] pos_mag_t;

endpackage

// ===== src/tick_if.sv
// millisecond tick and blink level from the divider to the sequencer
`timescale 1ns/100ps
interface tick_if;
    logic tick;
    logic blink;
    modport src (output tick, output blink);
    modport dst (input tick, input blink);
endinterface

// ===== src/tick_divider.sv
// divider for the millisecond tick and the indicator blink rate
`timescale 1ns/100ps
`include "sequencer_params.svh"
module tick_divider #(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int BLINK_TICKS = `BLINK_TICKS
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    tick_if.src ticks
);
    typedef struct packed {
        logic [15:0] cyc;
        logic [15:0] ms;
        logic tick;
        logic blink;
    } div_t;

    div_t s_q, s_d;

    if (TICK_CYCLES < 2 || TICK_CYCLES > 65535 || BLINK_TICKS < 1 || BLINK_TICKS > 65535)
    begin : g_bad
        $error("tick_divider: counts out of range");
    end

    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cyc == 16'(TICK_CYCLES - 1))
        begin
            s_d.cyc = 16'h0000;
            s_d.tick = 1'b1;
            if (s_q.ms == 16'(BLINK_TICKS - 1))
            begin
                s_d.ms = 16'h0000;
                s_d.blink = ~s_q.blink;
            end
            else
                s_d.ms = s_q.ms + 16'h0001;
        end
        else
            s_d.cyc = s_q.cyc + 16'h0001;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign ticks.tick = s_q.tick;
    assign ticks.blink = s_q.blink;

    property p_tick_single;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        ticks.tick |=> !ticks.tick;
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("tick lasted two cycles");
endmodule

// ===== src/mass_clamp_centre_sequencer.sv
// command sequencer for mass clamp, release and centring motors
`timescale 1ns/100ps
`include "sequencer_params.svh"
module mass_clamp_centre_sequencer
    import sequencer_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int STAGE_MAX_TICKS = `STAGE_MAX_TICKS
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clamp_cmd_n,
    input wire logic i_release_cmd_n,
    input wire logic i_recentre_cmd_n,
    input wire logic [2:0] i_end_stop,
    input wire logic [2:0] i_freed,
    input wire logic [2:0] i_level,
    input wire sequencer_pkg::pos_mag_t i_pos_mag [3],
    input wire logic [2:0] i_pos_neg,
    output logic [2:0] o_clamp_drive,
    output logic [2:0] o_free_drive,
    output logic [2:0] o_level_drive,
    output logic [2:0] o_centre_up,
    output logic [2:0] o_centre_down,
    output logic o_activity_indicator,
    output logic o_low_power,
    output logic o_clamped
);
    import sequencer_pkg::*;

    localparam logic [15:0] MIN_T = 16'(`CMD_MIN_TICKS);
    localparam logic [15:0] STAGE_T = 16'(STAGE_MAX_TICKS);
    localparam logic [15:0] GAP_T = 16'(`STAGE_GAP_TICKS);
    localparam logic [15:0] PULSE_T = 16'(`PULSE_TICKS);
    localparam logic [15:0] PGAP_T = 16'(`PULSE_GAP_TICKS);
    localparam logic [9:0] MAX_P = 10'(`MAX_PULSES);

    if (STAGE_MAX_TICKS < 1 || STAGE_MAX_TICKS > 65535)
    begin : g_bad
        $error("stage timeout out of range");
    end

    typedef struct packed {
        seq_state_t st;
        op_t op;
        op_t then_op;
        logic [1:0] axis;
        logic clamped;
        logic armed;
        logic [15:0] hold;
        logic [15:0] cnt;
        logic [9:0] pulses;
        logic [2:0] clamp_drv;
        logic [2:0] free_drv;
        logic [2:0] level_drv;
        logic [2:0] up_drv;
        logic [2:0] down_drv;
        logic led;
        logic sleep;
    } seq_t;

    seq_t s_q, s_d;
    tick_if ticks ();

    tick_divider #(
        .TICK_CYCLES(TICK_CYCLES),
        .BLINK_TICKS(`BLINK_TICKS)
    ) u_div (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .ticks(ticks)
    );

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    logic [2:0] low;
    logic all_high;
    logic many_low;
    logic any_over;
    logic accept;

    // farther from centre gives shorter wait
    function automatic logic [15:0] pulse_gap(input pos_mag_t mag);
        pulse_gap = PGAP_T + {8'h00, ~mag};
    endfunction

    function automatic logic [2:0] one_hot(input logic [1:0] ax);
        one_hot = 3'(3'h1 << ax);
    endfunction

    assign low = ~{i_recentre_cmd_n, i_release_cmd_n, i_clamp_cmd_n};
    assign all_high = (low == 3'h0);
    assign many_low = (low != 3'h0) && ((low & (low - 3'h1)) != 3'h0);
    assign any_over = (i_pos_mag[0] > `POS_OVER_CODE) || (i_pos_mag[1] > `POS_OVER_CODE)
                      || (i_pos_mag[2] > `POS_OVER_CODE);
    // a press counts once it has lasted the least hold time
    assign accept = (s_q.st == ST_IDLE) && s_q.armed && (s_q.hold >= MIN_T);

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.clamp_drv = 3'h0;
        s_d.free_drv = 3'h0;
        s_d.level_drv = 3'h0;
        s_d.up_drv = 3'h0;
        s_d.down_drv = 3'h0;
        s_d.led = 1'b0;
        if (all_high)
            s_d.hold = 16'h0000;
        else if (ticks.tick && s_q.hold != 16'hffff)
            s_d.hold = s_q.hold + 16'h0001;
        if (ticks.tick)
            s_d.cnt = s_q.cnt + 16'h0001;
        unique case (s_q.st)
            ST_IDLE:
            begin
                if (all_high)
                    s_d.armed = 1'b1;
                if (accept)
                begin
                    s_d.armed = 1'b0;
                    s_d.axis = 2'h0;
                    s_d.cnt = 16'h0000;
                    s_d.pulses = 10'h000;
                    s_d.then_op = OP_NONE;
                    s_d.st = ST_WAIT_HIGH;
                    if (many_low)
                        s_d.st = ST_WAIT_HIGH;
                    else if (low[0])
                    begin
                        s_d.op = s_q.clamped ? OP_RELEASE : OP_CLAMP;
                        s_d.then_op = s_q.clamped ? OP_CLAMP : OP_NONE;
                        s_d.st = s_q.clamped ? ST_REL_FREE : ST_CL_STAGE;
                    end
                    else if (low[1])
                    begin
                        s_d.op = s_q.clamped ? OP_RELEASE : OP_CLAMP;
                        s_d.then_op = s_q.clamped ? OP_NONE : OP_RELEASE;
                        s_d.st = s_q.clamped ? ST_REL_FREE : ST_CL_STAGE;
                    end
                    else if (!s_q.clamped && any_over)
                    begin
                        s_d.op = OP_CENTRE;
                        s_d.st = ST_CEN_CHECK;
                    end
                end
            end
            ST_CL_STAGE:
            begin
                s_d.led = 1'b1;
                if (i_end_stop[s_q.axis] || s_q.cnt >= STAGE_T)
                begin
                    s_d.cnt = 16'h0000;
                    if (s_q.axis == 2'h2)
                    begin
                        s_d.clamped = 1'b1;
                        s_d.led = 1'b0;
                        s_d.axis = 2'h0;
                        if (s_q.then_op == OP_RELEASE)
                        begin
                            s_d.op = OP_RELEASE;
                            s_d.then_op = OP_NONE;
                            s_d.st = ST_REL_FREE;
                        end
                        else
                            s_d.st = ST_WAIT_HIGH;
                    end
                    else
                    begin
                        s_d.led = 1'b0;
                        s_d.st = ST_CL_GAP;
                    end
                end
                else
                    s_d.clamp_drv = one_hot(s_q.axis);
            end
            ST_CL_GAP:
            begin
                if (s_q.cnt >= GAP_T)
                begin
                    s_d.cnt = 16'h0000;
                    s_d.axis = s_q.axis + 2'h1;
                    s_d.st = ST_CL_STAGE;
                end
            end
            ST_REL_FREE:
            begin
                s_d.led = 1'b1;
                // an axis that is already free is not driven again
                if (i_freed[s_q.axis] || s_q.cnt >= STAGE_T)
                begin
                    s_d.cnt = 16'h0000;
                    s_d.pulses = 10'h000;
                    s_d.st = (s_q.axis == 2'h0) ? ST_CEN_CHECK : ST_REL_LEVEL;
                end
                else
                    s_d.free_drv = one_hot(s_q.axis);
            end
            ST_REL_LEVEL:
            begin
                s_d.led = 1'b1;
                if (i_level[s_q.axis] || s_q.cnt >= STAGE_T)
                begin
                    s_d.cnt = 16'h0000;
                    s_d.st = ST_CEN_CHECK;
                end
                else
                    s_d.level_drv = one_hot(s_q.axis);
            end
            ST_CEN_CHECK:
            begin
                s_d.led = ticks.blink;
                s_d.cnt = 16'h0000;
                if (i_pos_mag[s_q.axis] <= `POS_DONE_CODE || s_q.pulses == MAX_P)
                begin
                    s_d.pulses = 10'h000;
                    if (s_q.axis != 2'h2)
                    begin
                        s_d.axis = s_q.axis + 2'h1;
                        s_d.st = (s_q.op == OP_RELEASE) ? ST_REL_FREE : ST_CEN_CHECK;
                    end
                    else if (s_q.op == OP_RELEASE)
                    begin
                        // fresh release: follow with a full centring round
                        s_d.clamped = 1'b0;
                        s_d.op = OP_CENTRE;
                        s_d.axis = 2'h0;
                    end
                    else
                    begin
                        s_d.axis = 2'h0;
                        s_d.led = 1'b0;
                        if (s_q.then_op == OP_CLAMP)
                        begin
                            s_d.clamped = 1'b0;
                            s_d.op = OP_CLAMP;
                            s_d.then_op = OP_NONE;
                            s_d.st = ST_CL_STAGE;
                        end
                        else
                            s_d.st = ST_WAIT_HIGH;
                    end
                end
                else
                    s_d.st = ST_CEN_PULSE;
            end
            ST_CEN_PULSE:
            begin
                s_d.led = ticks.blink;
                // direction follows the side the mass is on, so an overshoot reverses it
                if (i_pos_neg[s_q.axis])
                    s_d.up_drv = one_hot(s_q.axis);
                else
                    s_d.down_drv = one_hot(s_q.axis);
                if (s_q.cnt >= PULSE_T)
                begin
                    s_d.up_drv = 3'h0;
                    s_d.down_drv = 3'h0;
                    s_d.cnt = 16'h0000;
                    s_d.pulses = s_q.pulses + 10'h001;
                    s_d.st = ST_CEN_GAP;
                end
            end
            ST_CEN_GAP:
            begin
                s_d.led = ticks.blink;
                if (s_q.cnt >= pulse_gap(i_pos_mag[s_q.axis]))
                    s_d.st = ST_CEN_CHECK;
            end
            ST_WAIT_HIGH:
            begin
                if (all_high)
                begin
                    s_d.armed = 1'b1;
                    s_d.op = OP_NONE;
                    s_d.st = ST_IDLE;
                end
            end
        endcase
        s_d.sleep = (s_d.st == ST_IDLE) && all_high;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.op <= OP_NONE;
            s_q.then_op <= OP_NONE;
            s_q.clamped <= `CLAMPED_AT_RESET;
        end
        else
            s_q <= s_d;
    end

    assign o_clamp_drive = s_q.clamp_drv;
    assign o_free_drive = s_q.free_drv;
    assign o_level_drive = s_q.level_drv;
    assign o_centre_up = s_q.up_drv;
    assign o_centre_down = s_q.down_drv;
    assign o_activity_indicator = s_q.led;
    assign o_low_power = s_q.sleep;
    assign o_clamped = s_q.clamped;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    logic any_drv;
    assign any_drv = |{s_q.clamp_drv, s_q.free_drv, s_q.level_drv, s_q.up_drv, s_q.down_drv};

    property p_one_motor;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $onehot0({s_q.clamp_drv, s_q.free_drv, s_q.level_drv, s_q.up_drv, s_q.down_drv});
    endproperty
    a_one_motor: assert property (p_one_motor) else $error("two motors at once");

    property p_no_centre_clamped;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (|{s_q.up_drv, s_q.down_drv}) |-> !s_q.clamped || s_q.op == OP_RELEASE;
    endproperty
    a_no_centre_clamped: assert property (p_no_centre_clamped)
        else $error("centring clamped");

    property p_gap_dark;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (s_q.st == ST_CL_STAGE) ##1 (s_q.st == ST_CL_GAP) |-> !o_activity_indicator;
    endproperty
    a_gap_dark: assert property (p_gap_dark) else $error("indicator lit in clamp gap");

    property p_clamp_done_dark;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(s_q.clamped) |-> !o_activity_indicator ##1 (s_q.st != ST_CL_GAP);
    endproperty
    a_clamp_done_dark: assert property (p_clamp_done_dark)
        else $error("indicator after clamp");

    property p_sleep;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (s_q.st == ST_IDLE && all_high) [*2] |-> o_low_power;
    endproperty
    a_sleep: assert property (p_sleep) else $error("no low power when idle");

    property p_recentre_quiet;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (accept && low == 3'h4 && (s_q.clamped || !any_over)) |=> (!any_drv) [*8];
    endproperty
    a_recentre_quiet: assert property (p_recentre_quiet) else $error("recentre moved");

    property p_invalid;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (accept && many_low) |=> (s_q.st == ST_WAIT_HIGH && !any_drv) [*4];
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid command acted");

    property p_min_hold;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (s_q.st == ST_IDLE) ##1 (s_q.st != ST_IDLE) |-> $past(s_q.hold) >= MIN_T;
    endproperty
    a_min_hold: assert property (p_min_hold) else $error("short press accepted");

    property p_stage_order;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        // the drive is registered one cycle after the stage state is entered
        $rose(s_q.clamp_drv[1]) |-> $past(s_q.axis) == 2'h1 && $past(s_q.st, 2) == ST_CL_GAP;
    endproperty
    a_stage_order: assert property (p_stage_order) else $error("clamp stage order");
endmodule

// ===== verif/mass_plant.sv
// mechanical model of clamps, bases and masses facing the sequencer
`timescale 1ns/100ps
module mass_plant
    import sequencer_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic [8:0] i_drv,
    input wire logic [2:0] i_up,
    input wire logic [2:0] i_down,
    input wire logic [2:0] i_kick,
    input wire logic [7:0] i_rnd,
    output logic [2:0] o_end_stop,
    output logic [2:0] o_freed,
    output logic [2:0] o_level,
    output sequencer_pkg::pos_mag_t o_pos_mag [3],
    output logic [2:0] o_pos_neg
);
    logic [4:0] cnt [3] = '{default: 5'h0};
    logic [8:0] drv_q = 9'h0;
    logic [2:0] pul_q = 3'h0;
    logic [2:0] over_q = 3'h0;
    logic [2:0] d3, p3;
    pos_mag_t m;
    initial
    begin
        o_end_stop = 3'h7;
        o_freed = 3'h0;
        o_level = 3'h0;
        o_pos_neg = 3'h0;
        o_pos_mag = '{default: 8'h40};
    end
    // ----------------------------------------
    // motors act after 16 steady cycles
    // ----------------------------------------
    always @(posedge i_clk_sys)
    begin
        drv_q <= i_drv;
        pul_q <= i_up | i_down;
        for (int a = 0; a < 3; a++)
        begin
            d3 = {i_drv[a + 6], i_drv[a + 3], i_drv[a]};
            p3 = {drv_q[a + 6], drv_q[a + 3], drv_q[a]};
            // a change of motor restarts the travel time
            cnt[a] <= (d3 != p3 || d3 == 3'h0) ? 5'h0 : cnt[a] + 5'h1;
            if (cnt[a] == 5'h10 && d3[0])
            begin
                o_end_stop[a] <= 1'b1;
                o_freed[a] <= 1'b0;
                o_level[a] <= 1'b0;
                o_pos_mag[a] <= 8'h40;
            end
            if (cnt[a] == 5'h10 && d3[1])
            begin
                o_end_stop[a] <= 1'b0;
                o_freed[a] <= 1'b1;
                o_pos_mag[a] <= 8'h90 + 8'(i_rnd[4:0]);
                o_pos_neg[a] <= i_rnd[5 + a];
            end
            if (cnt[a] == 5'h10 && d3[2])
                o_level[a] <= (a != 0);
            if (i_kick[a])
            begin
                o_pos_mag[a] <= 8'ha0;
                over_q[a] <= 1'b1;
            end
            m = o_pos_mag[a];
            // a mass moves when its pulse ends; a kicked mass overshoots once
            if (pul_q[a] && !(i_up[a] | i_down[a]))
            begin
                over_q[a] <= 1'b0;
                if (over_q[a] || m < 8'h60)
                    o_pos_neg[a] <= !o_pos_neg[a];
                o_pos_mag[a] <= over_q[a] ? 8'h60 : (m < 8'h60 ? 8'h60 - m : m - 8'h60);
            end
        end
    end
endmodule

// ===== verif/tb_mass_clamp_centre_sequencer.sv
// self-checking bench of the mass clamp and centre sequencer
`timescale 1ns/100ps
module tb_mass_clamp_centre_sequencer;
    import sequencer_pkg::*;
    localparam int TK = 2;
    localparam int LIMIT = 60000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] cmd_n = 3'h7;
    logic [2:0] kick = 3'h0;
    logic [7:0] rnd = 8'h0;
    logic [2:0] es, fr, lv, pn, cd, fd, ld, cu, cw;
    pos_mag_t pm [3];
    logic ind, lp, cl;
    logic [8:0] dv, dq = 9'h0;
    logic [31:0] seed = 32'hfe63;
    logic [31:0] seq;
    logic [2:0] cq = 3'h0, cen, upm, dnm;
    logic iq = 1'b0;
    int mot, falls, lit, kax, pend, g1, grel, cyc = 0, n_errors = 0, n_tests = 0;
    assign dv = {ld, fd, cd};

    mass_clamp_centre_sequencer #(.TICK_CYCLES(TK), .STAGE_MAX_TICKS(50)) dut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_clamp_cmd_n(cmd_n[0]),
        .i_release_cmd_n(cmd_n[1]), .i_recentre_cmd_n(cmd_n[2]),
        .i_end_stop(es), .i_freed(fr), .i_level(lv), .i_pos_mag(pm), .i_pos_neg(pn),
        .o_clamp_drive(cd), .o_free_drive(fd), .o_level_drive(ld), .o_centre_up(cu),
        .o_centre_down(cw), .o_activity_indicator(ind), .o_low_power(lp), .o_clamped(cl));
    mass_plant plant (
        .i_clk_sys(clk), .i_drv(dv), .i_up(cu), .i_down(cw), .i_kick(kick), .i_rnd(rnd),
        .o_end_stop(es), .o_freed(fr), .o_level(lv), .o_pos_mag(pm), .o_pos_neg(pn));

    initial
    begin
        forever #25 clk = ~clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // motor starts coded 4..6 clamp, 7..9 free, a..c level, axis order inside
    function automatic logic [31:0] exp_seq(input op_t op, input logic was_cl);
        case (op)
            OP_CLAMP: return was_cl ? 32'h78b9c456 : 32'h456;
            OP_RELEASE: return was_cl ? 32'h78b9c : 32'h45678b9c;
            default: return 32'h0;
        endcase
    endfunction
    // the given lines low for a while, then all high; waits for idle
    task automatic cmd(input logic [2:0] low, input int ms);
        int hold;
        seed = xs(seed);
        rnd = seed[7:0];
        hold = ms > 200 ? ms + 10 * int'(seed[11:8]) : ms;
        seq = 32'h0;
        mot = 0;
        falls = 0;
        lit = 0;
        pend = 0;
        g1 = 0;
        cen = 3'h0;
        upm = 3'h0;
        dnm = 3'h0;
        cmd_n = ~low;
        repeat (hold * TK) @(posedge clk);
        #2 cmd_n = 3'h7;
        for (int i = 0; i < 20000 && lp !== 1'b1; i++)
            @(posedge clk);
        #2;
        chk(lp, 1'b1, "idle reached");
        chk(ind, 1'b0, "indicator at idle");
    endtask
    // ----------------------------------------
    // monitor
    // ----------------------------------------
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_errors++;
            test_done();
        end
        for (int k = 0; k < 9; k++)
            if (dv[k] && !dq[k])
                seq = {seq[27:0], 4'(k + 4)};
        for (int a = 0; a < 3; a++)
            if ((cu[a] | cw[a]) && !cq[a])
            begin
                cen[a] = 1'b1;
                upm[a] |= cu[a];
                dnm[a] |= cw[a];
                chk(cu[a], pn[a], "pulse direction");
            end
        // spacing from a pulse end to the next motor start of any kind
        if (cq != 3'h0 && (cu | cw) == 3'h0)
            pend = cyc;
        if (g1 == 0 && pend != 0 && ((dv & ~dq) != 9'h0 || ((cu | cw) & ~cq) != 3'h0))
            g1 = cyc - pend;
        if (dv != 9'h0 || (cu | cw) != 3'h0)
        begin
            mot++;
            chk(lp, 1'b0, "low power while moving");
        end
        falls += int'(iq && !ind);
        lit |= int'(ind);
        dq = dv;
        cq = cu | cw;
        iq = ind;
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        repeat (8) @(posedge clk);
        #2 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #2;
        chk(cl, 1'b1, "clamped after reset");
        chk(lp, 1'b1, "low power after reset");
        cmd(3'b001, 100);
        chk(mot, 0, "short press motion");
        cmd(3'b100, 300);
        chk(mot, 0, "centre while clamped");
        cmd(3'b011, 300);
        chk(mot, 0, "two lines low");
        cmd(3'b010, 300);
        chk(seq, exp_seq(OP_RELEASE, 1'b1), "release order");
        chk(cen, 3'h7, "axes centred");
        chk(32'(falls > 1), 1, "indicator flashing");
        chk(cl, 1'b0, "released state");
        chk(lit, 1, "indicator lit");
        grel = g1;
        cmd(3'b100, 300);
        chk(mot, 0, "centre with no offset");
        chk(lit, 0, "refused centre dark");
        kax = int'(seed[1:0]) % 3;
        kick = 3'(1 << kax);
        @(posedge clk);
        #2 kick = 3'h0;
        cmd(3'b100, 300);
        chk(cen, 3'(1 << kax), "centred axes");
        chk(upm & dnm, 3'(1 << kax), "reverse group");
        chk(seq, 32'h0, "no clamp motion");
        chk(32'(g1 < grel), 1, "pulse spacing");
        cmd(3'b010, 300);
        chk(seq, exp_seq(OP_RELEASE, 1'b0), "release again");
        cmd(3'b001, 300);
        chk(seq, exp_seq(OP_CLAMP, 1'b0), "clamp order");
        chk(falls, 3, "indicator dark between stages");
        chk(cl, 1'b1, "clamped state");
        cmd(3'b001, 300);
        chk(seq, exp_seq(OP_CLAMP, 1'b1), "clamp again");
        chk(lp, 1'b1, "idle low power");
        test_done();
    end
endmodule
